// file: hdl/cpx_defines.vh
`ifndef CPX_DEFINES_VH
`define CPX_DEFINES_VH
// Register byte offsets
`define CPX_OFF_INSTR 8'h00
`define CPX_OFF_BASE 8'h04
`define CPX_OFF_PC 8'h08
`define CPX_OFF_SRC 8'h0c
`define CPX_OFF_FLAGS 8'h10
`define CPX_OFF_STATUS 8'h14
`define CPX_OFF_NEWBASE 8'h18
`define CPX_OFF_ADDR 8'h1c
`define CPX_OFF_MOVE 8'h20
`define CPX_OFF_WORDS 8'h24
`define CPX_OFF_CONFIG 8'h28
// Instruction field positions
`define CPX_COND_HI 31
`define CPX_COND_LO 28
`define CPX_BIT_P 24
`define CPX_BIT_U 23
`define CPX_BIT_N 22
`define CPX_BIT_W 21
`define CPX_BIT_L 20
`define CPX_RN_HI 19
`define CPX_RN_LO 16
`define CPX_RD_HI 15
`define CPX_RD_LO 12
`define CPX_NUM_HI 11
`define CPX_NUM_LO 8
`define CPX_BIT_RT 4
`define CPX_OFF8_HI 7
`define CPX_OFF8_LO 0
// Class patterns
`define CPX_CLS_XFER 3'h6
`define CPX_CLS_REG 4'he
// Constants
`define CPX_INT_CP 4'hf
`define CPX_PC_REG 4'hf
`define CPX_PC_BASE_ADJ 32'h00000008
`define CPX_PC_SRC_ADJ 32'h0000000c
`define CPX_WORD_BYTES 32'h00000004
`define CPX_WORD_SHIFT 2
// Coprocessor operation codes
`define CPX_OP_LOAD 2'h0
`define CPX_OP_STORE 2'h1
`define CPX_OP_TO_CORE 2'h2
`define CPX_OP_TO_CP 2'h3
// Reset values
`define CPX_RST_WORD 32'h00000000
`define CPX_RST_FLAGS 4'h0
`define CPX_RST_CONFIG 1'b0
`endif

// file: hdl/cpx_transfer_exec.v
// Summary of operation
// - Execute only when the condition field passes against current flags; else no effect.
// - Core makes every memory address; coprocessor moves data and decides word count.
// - Eight-bit offset shifted left two, added when up bit set, else subtracted.
// - Pre-index applies offset before use; post-index uses unmodified base first.
// - Write modified base back only when write-back bit set, post-index included.
// - First word at transfer address, each further word one word higher.
// - Low two address bits go out unmodified to the memory system.
// - Program counter as base reads instruction address plus eight.
// - Memory abort raises data abort trap, still writes base back, keeps other state.
// - Abort handling ignores the late-abort configuration bit.
// - Move to program counter copies bits 31..28 into flags, nothing else changes.
// - Move from program counter sends program counter plus twelve.
// - Direction bit set means coprocessor to core, clear means core to coprocessor.
// - Register transfers for coprocessor fifteen go to the internal control coprocessor.
// - With EXT_CP_EN clear, only register transfers to coprocessor fifteen accepted; all else undefined trap.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cpx_defines.vh"
module cpx_transfer_exec #(
  parameter EXT_CP_EN = 0
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg mem_req,
  output reg mem_write,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  input wire mem_abort,
  output reg cp_req,
  output reg [1:0] cp_op,
  output reg [3:0] cp_num,
  output reg cp_int_sel,
  output reg [31:0] cp_instr,
  output reg [31:0] cp_wdata,
  output reg cp_wvalid,
  input wire [31:0] cp_rdata,
  input wire cp_rvalid,
  input wire cp_last,
  output reg undef_trap,
  output reg abort_trap,
  output reg busy
);

  localparam S_IDLE = 3'd0;
  localparam S_DECODE = 3'd1;
  localparam S_FETCH = 3'd2;
  localparam S_MEM = 3'd3;
  localparam S_MOVE = 3'd4;
  localparam S_WB = 3'd5;

  // Condition field evaluation against N Z C V
  function cond_pass;
    input [3:0] cond;
    input [3:0] f;
    reg n, z, c, v;
    begin
      n = f[3];
      z = f[2];
      c = f[1];
      v = f[0];
      case (cond)
        4'h0: cond_pass = z;
        4'h1: cond_pass = ~z;
        4'h2: cond_pass = c;
        4'h3: cond_pass = ~c;
        4'h4: cond_pass = n;
        4'h5: cond_pass = ~n;
        4'h6: cond_pass = v;
        4'h7: cond_pass = ~v;
        4'h8: cond_pass = c & ~z;
        4'h9: cond_pass = ~c | z;
        4'ha: cond_pass = (n == v);
        4'hb: cond_pass = (n != v);
        4'hc: cond_pass = ~z & (n == v);
        4'hd: cond_pass = z | (n != v);
        4'he: cond_pass = 1'b1;
        default: cond_pass = 1'b0;
      endcase
    end
  endfunction

  reg [2:0] state_q;
  reg [31:0] instr_q;
  reg [31:0] base_q;
  reg [31:0] pc_q;
  reg [31:0] src_q;
  reg [3:0] flags_q;
  reg late_abort_q;
  reg [31:0] newbase_q;
  reg [31:0] move_q;
  reg [31:0] words_q;
  reg last_q;
  reg done_q;
  reg skipped_q;
  reg wb_q;

  // Register bus decode
  wire setup = psel & ~penable;
  wire wr_fire = psel & penable & pready & pwrite;
  // A write answered with an error must not start anything, even if busy fell meanwhile
  wire start = wr_fire & (paddr == `CPX_OFF_INSTR) & ~busy & ~pslverr;

  // Instruction fields and decode
  wire is_xfer = (instr_q[27:25] == `CPX_CLS_XFER);
  wire is_reg = (instr_q[27:24] == `CPX_CLS_REG) & instr_q[`CPX_BIT_RT];
  wire [3:0] num = instr_q[`CPX_NUM_HI:`CPX_NUM_LO];
  wire [3:0] rn = instr_q[`CPX_RN_HI:`CPX_RN_LO];
  wire [3:0] rd = instr_q[`CPX_RD_HI:`CPX_RD_LO];
  wire num_int = (num == `CPX_INT_CP);
  wire accept = is_reg ? (num_int | (EXT_CP_EN != 0))
                       : (is_xfer & (EXT_CP_EN != 0));
  wire [31:0] base_val = (rn == `CPX_PC_REG) ? pc_q + `CPX_PC_BASE_ADJ : base_q;
  wire [31:0] woff = {22'h000000, instr_q[`CPX_OFF8_HI:`CPX_OFF8_LO], 2'b00};
  wire [31:0] mod_base = instr_q[`CPX_BIT_U] ? base_val + woff : base_val - woff;
  wire [31:0] xfer_addr = instr_q[`CPX_BIT_P] ? mod_base : base_val;
  // Base write-back to the program counter is not a legal form, so it is dropped
  wire do_wb = instr_q[`CPX_BIT_W] & (rn != `CPX_PC_REG);

  // APB read mux, captured in the setup cycle
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (paddr)
      `CPX_OFF_INSTR: rd_mux = instr_q;
      `CPX_OFF_BASE: rd_mux = base_q;
      `CPX_OFF_PC: rd_mux = pc_q;
      `CPX_OFF_SRC: rd_mux = src_q;
      `CPX_OFF_FLAGS: rd_mux = {28'h0000000, flags_q};
      `CPX_OFF_STATUS: rd_mux = {26'h0000000, wb_q, skipped_q, done_q, abort_trap,
                                 undef_trap, busy};
      `CPX_OFF_NEWBASE: rd_mux = newbase_q;
      `CPX_OFF_ADDR: rd_mux = mem_addr;
      `CPX_OFF_MOVE: rd_mux = move_q;
      `CPX_OFF_WORDS: rd_mux = words_q;
      `CPX_OFF_CONFIG: rd_mux = {31'h00000000, late_abort_q};
      default: begin
        rd_mux = `CPX_RST_WORD;
        rd_hit = 1'b0;
      end
    endcase
  end

  // No wait states: ready rises in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= `CPX_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? `CPX_RST_WORD : rd_mux;
        // Unmapped addresses and instruction writes while busy are refused
        pslverr <= ~rd_hit | (pwrite & busy & (paddr == `CPX_OFF_INSTR));
      end else if (pready) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Software-written registers; hardware updates of base and flags take priority
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= `CPX_RST_WORD;
      pc_q <= `CPX_RST_WORD;
      src_q <= `CPX_RST_WORD;
      late_abort_q <= `CPX_RST_CONFIG;
    end else if (wr_fire) begin
      if (start)
        instr_q <= pwdata;
      if (paddr == `CPX_OFF_PC && !busy)
        pc_q <= pwdata;
      if (paddr == `CPX_OFF_SRC && !busy)
        src_q <= pwdata;
      // Stored and readable only; abort behaviour never looks at it
      if (paddr == `CPX_OFF_CONFIG)
        late_abort_q <= pwdata[0];
    end
  end

  // Execution sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      base_q <= `CPX_RST_WORD;
      flags_q <= `CPX_RST_FLAGS;
      newbase_q <= `CPX_RST_WORD;
      move_q <= `CPX_RST_WORD;
      words_q <= `CPX_RST_WORD;
      last_q <= 1'b0;
      done_q <= 1'b0;
      skipped_q <= 1'b0;
      wb_q <= 1'b0;
      busy <= 1'b0;
      undef_trap <= 1'b0;
      abort_trap <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= `CPX_RST_WORD;
      mem_wdata <= `CPX_RST_WORD;
      cp_req <= 1'b0;
      cp_op <= `CPX_OP_LOAD;
      cp_num <= 4'h0;
      cp_int_sel <= 1'b0;
      cp_instr <= `CPX_RST_WORD;
      cp_wdata <= `CPX_RST_WORD;
      cp_wvalid <= 1'b0;
    end else begin
      cp_wvalid <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (wr_fire && paddr == `CPX_OFF_BASE && !busy)
            base_q <= pwdata;
          if (wr_fire && paddr == `CPX_OFF_FLAGS && !busy)
            flags_q <= pwdata[3:0];
          if (start) begin
            busy <= 1'b1;
            done_q <= 1'b0;
            skipped_q <= 1'b0;
            wb_q <= 1'b0;
            undef_trap <= 1'b0;
            abort_trap <= 1'b0;
            words_q <= `CPX_RST_WORD;
            state_q <= S_DECODE;
          end
        end
        S_DECODE: begin
          if (!cond_pass(instr_q[`CPX_COND_HI:`CPX_COND_LO], flags_q)) begin
            skipped_q <= 1'b1;
            state_q <= S_WB;
          end else if (!accept) begin
            // Trap is raised before any bus or register side effect
            undef_trap <= 1'b1;
            state_q <= S_WB;
          end else begin
            cp_req <= 1'b1;
            cp_num <= num;
            cp_int_sel <= num_int;
            // Coprocessor fields pass through undecoded
            cp_instr <= instr_q;
            newbase_q <= mod_base;
            if (is_reg) begin
              if (instr_q[`CPX_BIT_L]) begin
                cp_op <= `CPX_OP_TO_CORE;
              end else begin
                cp_op <= `CPX_OP_TO_CP;
                cp_wdata <= (rd == `CPX_PC_REG) ? pc_q + `CPX_PC_SRC_ADJ : src_q;
                cp_wvalid <= 1'b1;
              end
              state_q <= S_MOVE;
            end else begin
              // Address low bits are left as computed for the memory system
              mem_addr <= xfer_addr;
              mem_write <= ~instr_q[`CPX_BIT_L];
              if (instr_q[`CPX_BIT_L]) begin
                cp_op <= `CPX_OP_LOAD;
                mem_req <= 1'b1;
                state_q <= S_MEM;
              end else begin
                cp_op <= `CPX_OP_STORE;
                state_q <= S_FETCH;
              end
            end
          end
        end
        S_FETCH: begin
          // Store: coprocessor hands over the next word and says if it is the last
          if (cp_rvalid) begin
            mem_wdata <= cp_rdata;
            last_q <= cp_last;
            mem_req <= 1'b1;
            state_q <= S_MEM;
          end
        end
        S_MEM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            words_q <= words_q + 32'h00000001;
            if (mem_abort) begin
              // Same path regardless of the late-abort setting
              abort_trap <= 1'b1;
              state_q <= S_WB;
            end else begin
              if (!mem_write) begin
                cp_wdata <= mem_rdata;
                cp_wvalid <= 1'b1;
              end
              if ((mem_write && last_q) || (!mem_write && cp_last)) begin
                state_q <= S_WB;
              end else begin
                mem_addr <= mem_addr + `CPX_WORD_BYTES;
                if (mem_write) begin
                  state_q <= S_FETCH;
                end else begin
                  mem_req <= 1'b1;
                end
              end
            end
          end
        end
        S_MOVE: begin
          if (cp_op == `CPX_OP_TO_CP) begin
            state_q <= S_WB;
          end else if (cp_rvalid) begin
            if (rd == `CPX_PC_REG)
              flags_q <= cp_rdata[31:28];
            else
              move_q <= cp_rdata;
            state_q <= S_WB;
          end
        end
        S_WB: begin
          // Base write-back also happens after an abort; skips and undefined traps leave it
          if (is_xfer && do_wb && !skipped_q && !undef_trap) begin
            base_q <= newbase_q;
            wb_q <= 1'b1;
          end
          cp_req <= 1'b0;
          busy <= 1'b0;
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule // cpx_transfer_exec

// file: tb/cpx_transfer_exec_props.sv
`timescale 1ns/1ps
module cpx_props (
  input wire pclk,
  input wire presetn,
  input wire pready,
  input wire pslverr,
  input wire mem_req,
  input wire mem_write,
  input wire [31:0] mem_addr,
  input wire mem_ack,
  input wire mem_abort,
  input wire cp_req,
  input wire [1:0] cp_op,
  input wire [3:0] cp_num,
  input wire cp_int_sel,
  input wire [31:0] cp_instr,
  input wire undef_trap,
  input wire abort_trap,
  input wire busy
);
  reg have_q;
  reg [31:0] last_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Last acked word address; forgotten between instructions
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have_q <= 1'b0;
      last_q <= 32'h00000000;
    end else if (!cp_req) begin
      have_q <= 1'b0;
    end else if (mem_req && mem_ack) begin
      have_q <= 1'b1;
      last_q <= mem_addr;
    end
  end
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  int_sel_a: assert property (cp_req |-> cp_int_sel == (cp_num == 4'hf))
    else $error("internal select wrong");
  addr_step_a: assert property (cp_req && mem_req && have_q |-> mem_addr == last_q + 32'h4)
    else $error("word address not one word up");
  mem_dir_a: assert property (mem_req |-> cp_req && !cp_op[1] && mem_write == cp_op[0])
    else $error("memory cycle outside load or store");
  move_dir_a: assert property (cp_req |-> cp_op == {cp_instr[27:24] == 4'he, !cp_instr[20]})
    else $error("direction bit misread");
  abort_trap_a: assert property (mem_req && mem_ack && mem_abort |-> ##[1:4] abort_trap)
    else $error("abort not trapped");
  undef_clean_a: assert property ($rose(undef_trap) |-> !mem_req && !$past(mem_req))
    else $error("memory cycle before undefined trap");
  busy_a: assert property (cp_req |-> busy)
    else $error("offer while idle");
endmodule // cpx_props
bind cpx_transfer_exec cpx_props i_cpx_props (
  .pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .mem_abort(mem_abort), .cp_req(cp_req), .cp_op(cp_op), .cp_num(cp_num),
  .cp_int_sel(cp_int_sel), .cp_instr(cp_instr), .undef_trap(undef_trap),
  .abort_trap(abort_trap), .busy(busy)
);

// file: tb/cpx_far_model.sv
`timescale 1ns/1ps
module cpx_far_model (
  input wire pclk,
  input wire presetn,
  input wire mem_req,
  input wire mem_write,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output reg [31:0] mem_rdata,
  output reg mem_ack,
  output reg mem_abort,
  input wire cp_req,
  input wire [1:0] cp_op,
  input wire [3:0] cp_num,
  input wire [31:0] cp_instr,
  input wire [31:0] cp_wdata,
  input wire cp_wvalid,
  output reg [31:0] cp_rdata,
  output reg cp_rvalid,
  output wire cp_last,
  input wire [3:0] mem_wait,
  input wire [31:0] abort_addr,
  input wire [31:0] mv_data
);
  reg [31:0] mem [0:15];
  reg [31:0] alog [0:15];
  reg [31:0] last_w;
  reg [3:0] wcnt, widx, na;
  reg need_q, req_q;
  integer i;
  wire mine = cp_req && cp_num == 4'hf; // Other numbers ignored
  // Only the length bit is read; opcode and register fields are ours alone
  wire [3:0] words = cp_instr[22] ? 4'h4 : 4'h1; // Length bit
  // While ack stands, widx has already moved past the acked word
  assign cp_last = (mem_ack ? widx - 4'h1 : widx) == words - 4'h1;
  initial for (i = 0; i < 16; i = i + 1) mem[i] = 32'h50000000 + i;
  // Memory and coprocessor answers; idle buses toggle so stale data never matches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rdata <= 32'h0;
      cp_rdata <= 32'h0;
      {mem_ack, mem_abort, cp_rvalid, need_q, req_q} <= 5'h0;
      {wcnt, widx, na} <= 12'h0;
    end else begin
      req_q <= mine;
      {mem_ack, mem_abort, cp_rvalid} <= 3'h0;
      mem_rdata <= ~mem_rdata;
      cp_rdata <= ~cp_rdata;
      if (!cp_req) widx <= 4'h0;
      if (mine && !req_q) need_q <= cp_op == 2'h1 || cp_op == 2'h2;
      if (need_q) begin
        cp_rvalid <= 1'b1;
        cp_rdata <= cp_op[1] ? mv_data : 32'ha0000000 + widx;
        need_q <= 1'b0;
      end
      if (mem_req && !mem_ack) begin
        if (wcnt < mem_wait) wcnt <= wcnt + 4'h1;
        else begin
          wcnt <= 4'h0;
          mem_ack <= 1'b1;
          mem_abort <= mem_addr == abort_addr;
          alog[na] <= mem_addr;
          na <= na + 4'h1;
          widx <= widx + 4'h1;
          if (mem_write) mem[mem_addr[5:2]] <= mem_wdata;
          else mem_rdata <= mem[mem_addr[5:2]];
          if (mem_write && !cp_last) need_q <= 1'b1;
        end
      end
      if (cp_wvalid) last_w <= cp_wdata;
    end
  end
endmodule // cpx_far_model

// file: tb/cpx_transfer_exec_tb.sv
`timescale 1ns/1ps
module cpx_transfer_exec_tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] mem_wait = 4'h0;
  reg [31:0] abort_addr = 32'hffffffff;
  reg [31:0] mv_data = 32'h0;
  reg [31:0] rd;
  reg err;
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata, cp_instr, cp_wdata, cp_rdata;
  wire pready, pslverr, mem_req, mem_write, mem_ack, mem_abort, cp_req;
  wire cp_wvalid, cp_rvalid, cp_last;
  wire [1:0] cp_op;
  wire [3:0] cp_num;
  integer fail_count = 0;
  integer compares = 0;
  integer i;
  always #12.5 pclk = ~pclk;
  cpx_transfer_exec #(.EXT_CP_EN(1)) i_cpx_transfer_exec (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_abort(mem_abort), .cp_req(cp_req),
    .cp_op(cp_op), .cp_num(cp_num), .cp_int_sel(), .cp_instr(cp_instr), .cp_wdata(cp_wdata),
    .cp_wvalid(cp_wvalid), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid), .cp_last(cp_last),
    .undef_trap(), .abort_trap(), .busy()
  );
  cpx_far_model i_cpx_far_model (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .mem_abort(mem_abort), .cp_req(cp_req), .cp_op(cp_op), .cp_num(cp_num),
    .cp_instr(cp_instr), .cp_wdata(cp_wdata), .cp_wvalid(cp_wvalid), .cp_rdata(cp_rdata),
    .cp_rvalid(cp_rvalid), .cp_last(cp_last), .mem_wait(mem_wait),
    .abort_addr(abort_addr), .mv_data(mv_data)
  );
  // One APB transfer; request held until pready is seen at an edge
  // No local limit: only the watchdog ends a wait that never completes
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        $display("ERROR %s expected %h seen %h", nm, e, g);
        fail_count = fail_count + 1;
      end
    end
  endtask
  task rdc(input string nm, input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask
  // Start an instruction, then poll status until idle; rd keeps the status
  task run(input [31:0] ins);
    begin
      apb(1'b1, 8'h00, ins);
      rd = 32'h1;
      while (rd[0] !== 1'b0)
        apb(1'b0, 8'h14, 32'h0);
    end
  endtask
  function [31:0] xf(input [3:0] c, input [4:0] m, input [3:0] rn, input [7:0] off);
    xf = {c, 3'h6, m, rn, 4'h1, 4'hf, off};
  endfunction
  function [31:0] rm(input l, input [3:0] r);
    rm = {8'hee, 3'h1, l, 4'h2, r, 4'hf, 3'h0, 1'b1, 4'h3};
  endfunction
  task end_sim;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #500000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status", 8'h14, 32'h0);
    rdc("config", 8'h28, 32'h0);
    rdc("flags", 8'h10, 32'h0);
    rdc("unmapped", 8'h3c, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("reset and map test done");
    apb(1'b1, 8'h04, 32'h100);
    run(xf(4'h0, 5'b11011, 4'h1, 8'h03));
    chk("skipped", 32'h1, {31'h0, rd[4]});
    rdc("base", 8'h04, 32'h100);
    run(xf(4'h1, 5'b11011, 4'h1, 8'h03));
    chk("addr", 32'h10c, i_cpx_far_model.alog[0]);
    chk("load", 32'h50000003, i_cpx_far_model.last_w);
    rdc("base", 8'h04, 32'h10c);
    $display("condition and pre-index test done");
    apb(1'b1, 8'h04, 32'h102);
    mem_wait <= 4'h2;
    run(xf(4'he, 5'b00100, 4'h1, 8'h01));
    for (i = 0; i < 4; i = i + 1) begin
      chk("addr", 32'h102 + 4 * i, i_cpx_far_model.alog[1 + i]);
      chk("store", 32'ha0000000 + i, i_cpx_far_model.mem[i]);
    end
    rdc("base", 8'h04, 32'h102);
    mem_wait <= 4'h0;
    apb(1'b1, 8'h08, 32'h200);
    run(xf(4'he, 5'b11001, 4'hf, 8'h02));
    chk("addr", 32'h210, i_cpx_far_model.alog[5]);
    $display("long store and pc base test done");
    for (i = 0; i < 2; i = i + 1) begin
      apb(1'b1, 8'h28, i);
      apb(1'b1, 8'h10, 32'h6);
      apb(1'b1, 8'h04, 32'h40);
      abort_addr <= 32'h40;
      run(xf(4'he, 5'b01111, 4'h1, 8'h05));
      chk("abort", 32'h1, {31'h0, rd[2]});
      rdc("base", 8'h04, 32'h54);
      rdc("flags", 8'h10, 32'h6);
    end
    abort_addr <= 32'hffffffff;
    $display("abort test done");
    mv_data <= 32'h9abcdef1;
    run(rm(1'b1, 4'hf));
    rdc("flags", 8'h10, 32'h9);
    rdc("pc", 8'h08, 32'h200);
    run(rm(1'b1, 4'h3));
    rdc("move", 8'h20, 32'h9abcdef1);
    run(rm(1'b0, 4'hf));
    chk("to_cp", 32'h20c, i_cpx_far_model.last_w);
    apb(1'b1, 8'h0c, 32'h1234);
    run(rm(1'b0, 4'h2));
    chk("to_cp", 32'h1234, i_cpx_far_model.last_w);
    run(32'hee000f00);
    chk("undef", 32'h1, {31'h0, rd[1]});
    $display("register move test done");
    end_sim;
  end
endmodule // cpx_transfer_exec_tb
